/* include/atgo_trim_map.vh */
// Register indices, field layout and reset values of the trim register group
`ifndef ATGO_TRIM_MAP_VH
`define ATGO_TRIM_MAP_VH

// Register indices; the byte address on the bus is four times the index
`define ATGO_IDX_OFFSET_TRIM_CORE5   10'h33E
`define ATGO_IDX_FINE_GAIN_BASE      10'h360
`define ATGO_IDX_FINE_GAIN_CORE0     10'h360
`define ATGO_IDX_FINE_GAIN_CORE1     10'h361
`define ATGO_IDX_FINE_GAIN_CORE2_A   10'h362
`define ATGO_IDX_FINE_GAIN_CORE2_B   10'h363
`define ATGO_IDX_FINE_GAIN_CORE3_C   10'h364
`define ATGO_IDX_FINE_GAIN_CORE3_D   10'h365
`define ATGO_IDX_FINE_GAIN_CORE4     10'h366
`define ATGO_IDX_FINE_GAIN_CORE5     10'h367

// Number of fine-gain trim registers
`define ATGO_GAIN_COUNT              8

// Fine-gain register layout
`define ATGO_GAIN_REG_W              8
`define ATGO_GAIN_FIELD_W            5
`define ATGO_GAIN_FIELD_MSB          4
`define ATGO_GAIN_FIELD_LSB          0
`define ATGO_GAIN_RSVD_MSB           7
`define ATGO_GAIN_RSVD_LSB           5

// Offset register layout
`define ATGO_OFS_REG_W               16
`define ATGO_OFS_FIELD_W             12
`define ATGO_OFS_FIELD_MSB           11
`define ATGO_OFS_FIELD_LSB           0
`define ATGO_OFS_RSVD_MSB            15
`define ATGO_OFS_RSVD_LSB            12

// Reset values
`define ATGO_GAIN_RESET              8'h00
`define ATGO_OFS_RESET               16'h0000
`define ATGO_RDATA_RESET             32'h00000000

`endif

/* src/atgo_trim_regs.v */
// Fine-gain and offset trim registers of the converter cores behind an APB slave
//
// How it works
// - Register 0x360 holds the core zero fine gain in bits 4:0.
// - Register 0x361 holds the core one fine gain in bits 4:0.
// - Core two uses the gain at 0x362 while it samples its first analog input.
// - Core two uses the gain at 0x363 while it samples its second analog input.
// - Core three uses the gain at 0x364 while it samples its third analog input.
// - Core three uses the gain at 0x365 while it samples its fourth analog input.
// - Register 0x366 holds the core four fine gain in bits 4:0.
// - Register 0x367 holds the core five fine gain in bits 4:0.
// - Gain trims reset to zero and then take their defaults from fuse storage.
// - Bits 11:0 of the offset register trim core five; bits 15:12 are reserved read/write.
// - The 16-bit core five offset register sits at 0x33E and resets to zero.
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "atgo_trim_map.vh"

module atgo_trim_regs (
    // APB clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Fuse storage defaults
    input  wire        fuse_load,
    input  wire [39:0] fuse_gain,
    input  wire [11:0] fuse_offset,
    // Analog input selection of the two muxed cores
    input  wire        core2_input_sel,
    input  wire        core3_input_sel,
    // Trims applied to the converter paths
    output reg  [4:0]  core0_gain_trim,
    output reg  [4:0]  core1_gain_trim,
    output reg  [4:0]  core2_gain_trim,
    output reg  [4:0]  core3_gain_trim,
    output reg  [4:0]  core4_gain_trim,
    output reg  [4:0]  core5_gain_trim,
    output reg  [11:0] core5_offset_trim
);

    // Storage
    reg  [7:0]  fine_gain_r [0:7];
    reg  [15:0] offset_trim_core5_r;

    // Address decode
    wire        word_aligned;
    wire [9:0]  reg_index;
    wire [7:0]  gain_hit;
    wire        offset_hit;
    wire        any_hit;
    wire        setup_phase;
    wire        access_done;
    wire        write_done;

    // Read path
    reg  [31:0] prdata_nxt;
    reg  [2:0]  gain_sel;

    assign word_aligned = (paddr[1:0] == 2'h0);
    assign reg_index    = paddr[11:2];
    assign offset_hit   = word_aligned && (reg_index == `ATGO_IDX_OFFSET_TRIM_CORE5);
    assign any_hit      = offset_hit || (gain_hit != 8'h00);
    assign setup_phase  = psel && !penable;
    assign access_done  = psel && penable && pready;
    assign write_done   = access_done && pwrite && !pslverr;

    // Each gain register is decoded, written and fuse-loaded the same way
    genvar gi;
    generate
        for (gi = 0; gi < `ATGO_GAIN_COUNT; gi = gi + 1) begin : g_gain
            // Sum kept at full width, then cut to the index width on purpose
            localparam [31:0] GAIN_IDX_FULL = `ATGO_IDX_FINE_GAIN_BASE + gi;

            assign gain_hit[gi] = word_aligned && (reg_index == GAIN_IDX_FULL[9:0]);

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fine_gain_r[gi] <= `ATGO_GAIN_RESET;
                end else if (write_done && gain_hit[gi]) begin
                    // Reserved bits are stored as written so they read back
                    fine_gain_r[gi] <= pwdata[7:0];
                end else if (fuse_load) begin
                    fine_gain_r[gi] <= {3'h0, fuse_gain[gi*5 +: 5]};
                end
            end
        end
    endgenerate

    // Offset register of core five
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offset_trim_core5_r <= `ATGO_OFS_RESET;
        end else if (write_done && offset_hit) begin
            offset_trim_core5_r <= pwdata[15:0];
        end else if (fuse_load) begin
            offset_trim_core5_r <= {4'h0, fuse_offset};
        end
    end

    // Read data, selected during the setup cycle so it is ready in the access cycle
    always @* begin
        prdata_nxt = `ATGO_RDATA_RESET;
        gain_sel   = reg_index[2:0];
        if (offset_hit) begin
            prdata_nxt = {16'h0000, offset_trim_core5_r};
        end else if (gain_hit != 8'h00) begin
            prdata_nxt = {24'h000000, fine_gain_r[gain_sel]};
        end
    end

    // APB answer: zero wait states, error on any unmapped or unaligned address
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= `ATGO_RDATA_RESET;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase && !any_hit;
            if (setup_phase && !pwrite) begin
                prdata <= prdata_nxt;
            end
        end
    end

    // Applied trims follow storage one cycle later, so a write lands on the next sample
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core0_gain_trim   <= 5'h00;
            core1_gain_trim   <= 5'h00;
            core2_gain_trim   <= 5'h00;
            core3_gain_trim   <= 5'h00;
            core4_gain_trim   <= 5'h00;
            core5_gain_trim   <= 5'h00;
            core5_offset_trim <= 12'h000;
        end else begin
            core0_gain_trim <= fine_gain_r[0][4:0];
            core1_gain_trim <= fine_gain_r[1][4:0];
            if (core2_input_sel) begin
                core2_gain_trim <= fine_gain_r[3][4:0];
            end else begin
                core2_gain_trim <= fine_gain_r[2][4:0];
            end
            if (core3_input_sel) begin
                core3_gain_trim <= fine_gain_r[5][4:0];
            end else begin
                core3_gain_trim <= fine_gain_r[4][4:0];
            end
            core4_gain_trim   <= fine_gain_r[6][4:0];
            core5_gain_trim   <= fine_gain_r[7][4:0];
            core5_offset_trim <= offset_trim_core5_r[11:0];
        end
    end

endmodule
`default_nettype wire

/* verification/atgo_trim_monitor.sv */
// Assertion checker for the trim register group
`timescale 1ns/100ps
`default_nettype none
module atgo_trim_monitor (
    // APB side
    input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    // Fuse defaults, input selects and the applied core five offset trim
    input wire logic        fuse_load, core2_input_sel, core3_input_sel,
    input wire logic [39:0] fuse_gain,
    input wire logic [11:0] fuse_offset, core5_offset_trim,
    // Applied trims
    input wire logic [4:0]  core0_gain_trim, core1_gain_trim, core2_gain_trim,
    input wire logic [4:0]  core3_gain_trim, core4_gain_trim, core5_gain_trim
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic ok = paddr == 12'hCF8 || (paddr[11:5] == 7'h6C && paddr[1:0] == 2'h0);
    wire logic wr = psel && penable && pready && pwrite && !pslverr && !fuse_load;
    a_ready_err_map: assert property (psel && !penable |=> pready && pslverr == !$past(ok))
        else $error("access answer or error flag wrong");
    a_ready_one: assert property (pready |=> !pready) else $error("pready held too long");
    a_fine_gain_core0_write: assert property (wr && paddr == 12'hD80 |-> ##2 core0_gain_trim == $past(pwdata[4:0], 2))
        else $error("core zero gain trim not applied");
    a_core2_first: assert property (wr && paddr == 12'hD88 && !core2_input_sel ##1 !core2_input_sel
        |=> core2_gain_trim == $past(pwdata[4:0], 2)) else $error("core two first input trim wrong");
    a_core3_fourth: assert property (wr && paddr == 12'hD94 && core3_input_sel ##1 core3_input_sel
        |=> core3_gain_trim == $past(pwdata[4:0], 2)) else $error("core three fourth input trim wrong");
    a_offset_write: assert property (wr && paddr == 12'hCF8 |-> ##2 core5_offset_trim == $past(pwdata[11:0], 2))
        else $error("core five offset trim not applied");
    a_reset_zero: assert property ($rose(presetn) |-> !pready && core5_offset_trim == 12'h000
        && {core0_gain_trim, core1_gain_trim, core2_gain_trim, core3_gain_trim} == 20'h00000)
        else $error("trims not zero after reset");
    a_fuse_load: assert property (fuse_load && !psel |-> ##2 core0_gain_trim == $past(fuse_gain[4:0], 2)
        && core5_offset_trim == $past(fuse_offset, 2)) else $error("fuse defaults not loaded");
    cover property (wr);
    cover property (pready && pslverr);
    cover property (fuse_load);
endmodule
bind atgo_trim_regs atgo_trim_monitor atgo_trim_monitor_inst (.*);
`default_nettype wire

/* verification/adc_trim_gain_offset_regs_tb.sv */
// Self-checking bench for the trim register group
`timescale 1ns/100ps
`default_nettype none
module adc_trim_gain_offset_regs_tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        fuse_load = 1'b0, core2_input_sel = 1'b0, core3_input_sel = 1'b1, pready, pslverr, err;
    logic [11:0] paddr = 12'h000, fuse_offset = 12'h6A3, core5_offset_trim;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [39:0] fuse_gain = 40'h9C3B5E7A21;
    logic [4:0]  core0_gain_trim, core1_gain_trim, core2_gain_trim, core3_gain_trim, core4_gain_trim, core5_gain_trim;
    // Rows: value written and read back; reserved bits kept zero
    logic [15:0] rv [9] = '{16'h0A5C, 16'h11, 16'h1F, 16'h02, 16'h15, 16'h04, 16'h0A, 16'h10, 16'h01};
    int          n_mismatch = 0, compares = 0;
    wire  [41:0] tv = {core0_gain_trim, core1_gain_trim, core2_gain_trim, core3_gain_trim,
                       core4_gain_trim, core5_gain_trim, core5_offset_trim};
    always #20 pclk = ~pclk;
    atgo_trim_regs atgo_trim_regs_inst (.*);
    function automatic logic [11:0] adr(input int i);
        return i == 0 ? 12'hCF8 : 12'hD7C + 12'(4 * i);
    endfunction
    function automatic logic [41:0] ex(input int s2, s3);
        return {rv[1][4:0], rv[2][4:0], rv[3 + s2][4:0], rv[5 + s3][4:0], rv[7][4:0], rv[8][4:0], rv[0][11:0]};
    endfunction
    task automatic stop_test;
        $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] exp, got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 16);
        if (n == 16) chk("pready timeout", 0, 1);
        if (n == 16) stop_test();
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            xfer(0, adr(i), 0);
            chk("reset value", 0, rdat);
        end
        for (int i = 0; i < 9; i++) begin
            xfer(1, adr(i), rv[i]);
            xfer(0, adr(i), 0);
            chk("readback", rv[i], rdat);
        end
        repeat (2) @(posedge pclk);
        chk("trims", ex(0, 1), tv);
        core2_input_sel <= 1'b1;
        core3_input_sel <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("muxed trims", ex(1, 0), tv);
        $display("Register rows done");
        xfer(1, 12'hD81, 32'h3);
        chk("unaligned error", 1, err);
        xfer(0, 12'hD80, 0);
        chk("ignored write", rv[1], rdat);
        xfer(0, 12'hD00, 0);
        chk("unmapped read", 33'h100000000, {err, rdat});
        $display("Refused accesses done");
        @(posedge pclk);
        fuse_load <= 1'b1;
        @(posedge pclk);
        fuse_load <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("fuse trims", {fuse_gain[4:0], fuse_gain[9:5], fuse_gain[19:15], fuse_gain[24:20],
            fuse_gain[34:30], fuse_gain[39:35], fuse_offset}, tv);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk("trims after reset", 0, tv);
        xfer(0, 12'hCF8, 0);
        chk("offset after reset", 0, rdat);
        $display("Fuse and reset done");
        stop_test();
    end
endmodule
`default_nettype wire
